// file: hw/hfc_tune_ctrl.sv
// Purpose: high frequency oscillator trim control and stepping
// Assumes: core_clk_i is the 40 MHz control clock domain
// Notes: trim writes arrive as a one-cycle strobe with a code
// Overview of operation
// - control logic and step timer run only from the 40 MHz control clock
// - oscillator nominal 20 MHz, trimmed roughly plus or minus twenty percent
// - codes 0-4 give 20-24 MHz, 9-12 give 16-19 MHz, rest unused
// - multi-step changes walk every intermediate step, waiting 5.2 us each
// - reaching target sets settled flag; unmasked flag drives low interrupt
// - oscillator divided by eight gives 2.0 to 3.0 MHz switching
// - power-up trim code is loaded from the one-time programmed field
// - no trim changes applied while spread spectrum or sync is active
// - supplies state machine clock, switching clocks and phase multiples
// - external sync forces spread spectrum off regardless of its enable
`timescale 1ns/1ps
`default_nettype none
module hfc_tune_ctrl (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic osc_clk_i,
  input wire logic [hfc_pkg::TRIM_W-1:0] otp_default_trim_code_i,
  input wire logic trim_wr_i,
  input wire logic [hfc_pkg::TRIM_W-1:0] trim_wdata_i,
  input wire logic spread_spectrum_enable_i,
  input wire logic ext_sync_enable_i,
  input wire logic settled_clr_i,
  input wire logic settled_mask_i,
  output logic [hfc_pkg::TRIM_W-1:0] hf_osc_trim_code_o,
  output logic [hfc_pkg::TRIM_W-1:0] target_trim_o,
  output logic stepping_o,
  output logic freq_settled_flag_o,
  output logic irq_out_n_o,
  output logic spread_active_o,
  output logic sm_clk_en_o,
  output logic sw_clk_o,
  output logic [hfc_pkg::PHASE_N-1:0] sw_phase_o
);
  import hfc_pkg::*;

  hfc_state_t state_reg;
  logic [IDX_W-1:0] cur_idx_reg;
  logic [IDX_W-1:0] tgt_idx_reg;
  logic [STEP_CNT_W-1:0] step_cnt_reg;
  logic loaded_reg;
  logic settle_evt;
  logic manual_ok;
  logic wr_take;
  logic [IDX_W-1:0] cur_seen_reg;
  logic [STEP_CNT_W-1:0] dwell_cnt_reg;

  // manual tuning locked out under spread spectrum or sync
  assign manual_ok = !ext_sync_enable_i && !spread_spectrum_enable_i;
  assign wr_take = trim_wr_i && trim_valid(trim_wdata_i) && manual_ok
                   && loaded_reg;
  assign settle_evt = (state_reg == HFC_STEP) &&
                      (step_cnt_reg == STEP_CNT_ZERO) &&
                      (cur_idx_reg == tgt_idx_reg);

  // default trim caught on the first clock after reset
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tgt_idx_reg <= IDX_NOMINAL;
    end else if (!loaded_reg) begin
      if (trim_valid(otp_default_trim_code_i)) begin
        tgt_idx_reg <= trim_to_idx(otp_default_trim_code_i);
      end
    end else if (wr_take) begin
      tgt_idx_reg <= trim_to_idx(trim_wdata_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= HFC_IDLE;
      cur_idx_reg <= IDX_NOMINAL;
      step_cnt_reg <= STEP_CNT_ZERO;
    end else if (!loaded_reg) begin
      state_reg <= HFC_IDLE;
      if (trim_valid(otp_default_trim_code_i)) begin
        cur_idx_reg <= trim_to_idx(otp_default_trim_code_i);
      end
    end else begin
      case (state_reg)
        HFC_IDLE: begin
          if (cur_idx_reg != tgt_idx_reg && manual_ok) begin
            state_reg <= HFC_STEP;
            step_cnt_reg <= STEP_CNT_ZERO;
            if (tgt_idx_reg > cur_idx_reg) begin
              cur_idx_reg <= cur_idx_reg + 4'h1;
            end else begin
              cur_idx_reg <= cur_idx_reg - 4'h1;
            end
          end
        end
        HFC_STEP: begin
          if (cur_idx_reg == tgt_idx_reg) begin
            state_reg <= HFC_IDLE;
          end else begin
            state_reg <= HFC_WAIT;
            step_cnt_reg <= STEP_CNT_LAST;
          end
        end
        HFC_WAIT: begin
          if (step_cnt_reg != STEP_CNT_ZERO) begin
            step_cnt_reg <= step_cnt_reg - 9'h001;
          end else if (manual_ok) begin
            state_reg <= HFC_STEP;
            if (tgt_idx_reg > cur_idx_reg) begin
              cur_idx_reg <= cur_idx_reg + 4'h1;
            end else if (tgt_idx_reg < cur_idx_reg) begin
              cur_idx_reg <= cur_idx_reg - 4'h1;
            end
          end
        end
        default: begin
          state_reg <= HFC_IDLE;
        end
      endcase
    end
  end

  // set wins over clear
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      freq_settled_flag_o <= 1'b0;
    end else if (settle_evt) begin
      freq_settled_flag_o <= 1'b1;
    end else if (settled_clr_i) begin
      freq_settled_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      irq_out_n_o <= 1'b1;
    end else begin
      irq_out_n_o <= !((freq_settled_flag_o || settle_evt) &&
                       !settled_mask_i);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hf_osc_trim_code_o <= idx_to_trim(IDX_NOMINAL);
      target_trim_o <= idx_to_trim(IDX_NOMINAL);
      stepping_o <= 1'b0;
      spread_active_o <= 1'b0;
      sm_clk_en_o <= 1'b0;
    end else begin
      hf_osc_trim_code_o <= idx_to_trim(cur_idx_reg);
      target_trim_o <= idx_to_trim(tgt_idx_reg);
      stepping_o <= (cur_idx_reg != tgt_idx_reg);
      spread_active_o <= spread_spectrum_enable_i &&
                         !ext_sync_enable_i;
      sm_clk_en_o <= 1'b1;
    end
  end

  hfc_sw_divider u_div (
    .osc_clk_i(osc_clk_i),
    .srst_i(srst_i),
    .run_i(loaded_reg),
    .sw_clk_o(sw_clk_o),
    .sw_phase_o(sw_phase_o)
  );

  // checker aid: cycles since the applied step moved, idle reads as long
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cur_seen_reg <= IDX_NOMINAL;
      dwell_cnt_reg <= '1;
    end else begin
      cur_seen_reg <= cur_idx_reg;
      if (state_reg == HFC_IDLE) begin
        dwell_cnt_reg <= '1;
      end else if (cur_idx_reg != cur_seen_reg) begin
        dwell_cnt_reg <= 9'h001;
      end else if (dwell_cnt_reg != '1) begin
        dwell_cnt_reg <= dwell_cnt_reg + 9'h001;
      end
    end
  end

  AST_STEP_GAP: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (cur_idx_reg != cur_seen_reg) |-> dwell_cnt_reg >= STEP_CYC)
    else $error("trim stepped too soon");
  AST_STEP_WAIT: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (state_reg == HFC_STEP && cur_idx_reg != tgt_idx_reg) |=>
    state_reg == HFC_WAIT && step_cnt_reg == STEP_CNT_LAST)
    else $error("step wait not loaded");
  AST_ONE_STEP: assert property (@(posedge core_clk_i) disable iff (srst_i)
    $changed(cur_idx_reg) && $past(loaded_reg) |->
    (cur_idx_reg == $past(cur_idx_reg) + 4'h1 ||
     cur_idx_reg == $past(cur_idx_reg) - 4'h1))
    else $error("trim jumped more than one step");
  AST_SETTLE_SET: assert property (@(posedge core_clk_i) disable iff (srst_i)
    settle_evt |=> freq_settled_flag_o)
    else $error("settled flag not set");
  AST_IRQ: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (freq_settled_flag_o && !settled_mask_i) |=> !irq_out_n_o)
    else $error("interrupt not driven");
  AST_LATCH: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (freq_settled_flag_o && !settled_clr_i) |=> freq_settled_flag_o)
    else $error("settled flag dropped");
  AST_IGNORE: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (loaded_reg && trim_wr_i && !trim_valid(trim_wdata_i)) |=>
    $stable(tgt_idx_reg))
    else $error("unused code accepted");
  AST_LOCK: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (loaded_reg && !manual_ok) |=> $stable(tgt_idx_reg))
    else $error("trim taken while locked");
  AST_SSOFF: assert property (@(posedge core_clk_i) disable iff (srst_i)
    ext_sync_enable_i |=> !spread_active_o)
    else $error("spread active during sync");
  AST_VALID_OUT: assert property (@(posedge core_clk_i) disable iff (srst_i)
    trim_valid(hf_osc_trim_code_o))
    else $error("unused trim code driven");
  COV_SETTLE: cover property (@(posedge core_clk_i) disable iff (srst_i)
    settle_evt);
  COV_DOWN: cover property (@(posedge core_clk_i) disable iff (srst_i)
    wr_take && trim_to_idx(trim_wdata_i) + 4'h2 <= cur_idx_reg);
  COV_CLR: cover property (@(posedge core_clk_i) disable iff (srst_i)
    freq_settled_flag_o ##1 !freq_settled_flag_o);
  COV_PAUSE: cover property (@(posedge core_clk_i) disable iff (srst_i)
    state_reg == HFC_WAIT && step_cnt_reg == STEP_CNT_ZERO && !manual_ok);
endmodule
`default_nettype wire

// file: hw/hfc_pkg.sv
// Purpose: constants for the high frequency clock tuning control
// Assumes: control clock is 40 MHz
// Notes: trim codes map onto a linear step index 0..8 (16..24 MHz)
package hfc_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned STEP_NS = 5200;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // least time: round up
  localparam int unsigned STEP_CYC =
    (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STEP_CNT_W = 9;
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_LAST =
    STEP_CNT_W'(STEP_CYC - 1);
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_ZERO = 9'h000;
  localparam int unsigned TRIM_W = 4;
  localparam int unsigned IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_NOMINAL = 4'h4;
  localparam logic [IDX_W-1:0] IDX_MAX = 4'h8;
  localparam logic [TRIM_W-1:0] TRIM_HIGH_LO = 4'h0;
  localparam logic [TRIM_W-1:0] TRIM_HIGH_HI = 4'h4;
  localparam logic [TRIM_W-1:0] TRIM_LOW_LO = 4'h9;
  localparam logic [TRIM_W-1:0] TRIM_LOW_HI = 4'hc;
  localparam int unsigned DIV_RATIO = 8;
  localparam int unsigned DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_HALF = 3'h3;
  localparam int unsigned PHASE_N = 4;
  typedef enum logic [1:0] {HFC_IDLE, HFC_WAIT, HFC_STEP} hfc_state_t;

  function automatic logic trim_valid(input logic [TRIM_W-1:0] c);
    trim_valid = (c <= TRIM_HIGH_HI) ||
                 (c >= TRIM_LOW_LO && c <= TRIM_LOW_HI);
  endfunction

  // trim code to step index: 16 MHz -> 0 .. 24 MHz -> 8
  function automatic logic [IDX_W-1:0] trim_to_idx(
      input logic [TRIM_W-1:0] c);
    if (c <= TRIM_HIGH_HI) begin
      trim_to_idx = c + IDX_NOMINAL;
    end else begin
      trim_to_idx = c - TRIM_LOW_LO;
    end
  endfunction

  function automatic logic [TRIM_W-1:0] idx_to_trim(
      input logic [IDX_W-1:0] i);
    if (i >= IDX_NOMINAL) begin
      idx_to_trim = i - IDX_NOMINAL;
    end else begin
      idx_to_trim = i + TRIM_LOW_LO;
    end
  endfunction
endpackage

// file: hw/hfc_sw_divider.sv
// Purpose: divide the oscillator by eight, with phase-shifted taps
// Assumes: osc_clk_i is the high frequency oscillator
// Notes: taps are spaced by two oscillator cycles
`timescale 1ns/1ps
`default_nettype none
module hfc_sw_divider (
  input wire logic osc_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  output logic sw_clk_o,
  output logic [hfc_pkg::PHASE_N-1:0] sw_phase_o
);
  import hfc_pkg::*;
  logic [DIV_W-1:0] cnt_reg;
  logic run_s1_reg;
  logic run_s2_reg;
  logic srst_s1_reg;
  logic srst_s2_reg;

  // run and reset both come from the control clock
  always_ff @(posedge osc_clk_i) begin
    run_s1_reg <= run_i;
    run_s2_reg <= run_s1_reg;
    srst_s1_reg <= srst_i;
    srst_s2_reg <= srst_s1_reg;
  end

  always_ff @(posedge osc_clk_i) begin
    if (srst_s2_reg || !run_s2_reg) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge osc_clk_i) begin
    if (srst_s2_reg) begin
      sw_clk_o <= 1'b0;
      sw_phase_o <= '0;
    end else begin
      sw_clk_o <= (cnt_reg > DIV_HALF);
      for (int p = 0; p < PHASE_N; p++) begin
        sw_phase_o[p] <= (3'(cnt_reg + 3'(2 * p)) > DIV_HALF);
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/hfc_host_model.sv
// Purpose: host processor model for trim and flag control
// Assumes: drives just after a rising edge of clk_i
// Notes: released write data shows the inverse of the last code
`timescale 1ns/1ps
`default_nettype none
module hfc_host_model (
  input wire logic clk_i,
  output logic trim_wr_o,
  output logic [hfc_pkg::TRIM_W-1:0] trim_wdata_o,
  output logic spread_spectrum_enable_o,
  output logic ext_sync_enable_o,
  output logic clr_o,
  output logic mask_o
);
  import hfc_pkg::*;
  initial begin
    trim_wr_o = 1'b0;
    trim_wdata_o = 4'h0;
    spread_spectrum_enable_o = 1'b0;
    ext_sync_enable_o = 1'b0;
    clr_o = 1'b0;
    mask_o = 1'b0;
  end
  task automatic write_trim(input logic [TRIM_W-1:0] c);
    @(posedge clk_i);
    #2;
    trim_wr_o = 1'b1;
    trim_wdata_o = c;
    @(posedge clk_i);
    #2;
    trim_wr_o = 1'b0;
    trim_wdata_o = ~c;
  endtask
  task automatic clear_flag();
    @(posedge clk_i);
    #2;
    clr_o = 1'b1;
    @(posedge clk_i);
    #2;
    clr_o = 1'b0;
  endtask
  task automatic set_modes(input logic ss, input logic sy, input logic m);
    @(posedge clk_i);
    #2;
    spread_spectrum_enable_o = ss;
    ext_sync_enable_o = sy;
    mask_o = m;
  endtask
  // trim nearest the external clock before locking to it
  task automatic sync_to(input logic [TRIM_W-1:0] c);
    write_trim(c);
    set_modes(1'b0, 1'b1, mask_o);
  endtask
endmodule
`default_nettype wire

// file: tb/test_hfc_tune_ctrl.sv
// Purpose: self-checking bench for the trim control block
// Assumes: 40 MHz control clock, 20 MHz oscillator
// Notes: host stimulus comes from the host model
`timescale 1ns/1ps
`default_nettype none
module test_hfc_tune_ctrl;
  import hfc_pkg::*;
  logic clk, osc, srst, wr, ss, sy, clr, mask, p;
  logic [TRIM_W-1:0] otp, wdata, code, tgt, prev;
  logic stepping, flag, irq_n, spread, sm_en, sw_clk;
  logic [PHASE_N-1:0] phase;
  int fail_count = 0;
  int num_checks = 0;
  int n;
  int bad;
  logic [1:0] hist;
  logic [TRIM_W-1:0] walk [5] = '{4'h2, 4'h1, 4'h0, 4'hc, 4'hb};
  hfc_tune_ctrl i_dut (.core_clk_i(clk), .srst_i(srst), .osc_clk_i(osc),
    .otp_default_trim_code_i(otp), .trim_wr_i(wr), .trim_wdata_i(wdata),
    .spread_spectrum_enable_i(ss), .ext_sync_enable_i(sy),
    .settled_clr_i(clr), .settled_mask_i(mask), .hf_osc_trim_code_o(code),
    .target_trim_o(tgt), .stepping_o(stepping), .freq_settled_flag_o(flag),
    .irq_out_n_o(irq_n), .spread_active_o(spread), .sm_clk_en_o(sm_en),
    .sw_clk_o(sw_clk), .sw_phase_o(phase));
  hfc_host_model i_host (.clk_i(clk), .trim_wr_o(wr), .trim_wdata_o(wdata),
    .spread_spectrum_enable_o(ss), .ext_sync_enable_o(sy), .clr_o(clr),
    .mask_o(mask));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    osc = 1'b0;
    #7;
    forever #25 osc = ~osc;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk_code(input logic [TRIM_W-1:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: code %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task automatic timed_out();
    fail_count++;
    $display("mismatch at %0t: wait timed out", $time);
    wrap_up();
  endtask
  task automatic wait_flag();
    n = 0;
    while (flag !== 1'b1 && n < 3000) begin
      cycles(1);
      n++;
    end
    if (n >= 3000) timed_out();
  endtask
  task automatic wait_change();
    prev = code;
    n = 0;
    while (code === prev && n < 1000) begin
      cycles(1);
      n++;
    end
    if (n >= 1000) timed_out();
  endtask
  initial begin
    srst = 1'b1;
    otp = 4'h2;
    cycles(16);
    srst = 1'b0;
    cycles(4);
    chk_code(tgt, 4'h2);
    chk_code(code, 4'h2);
    chk_bit(sm_en, 1'b1);
    i_host.clear_flag();
    i_host.write_trim(4'h3);
    wait_flag();
    chk_code(code, 4'h3);
    cycles(2);
    chk_bit(irq_n, 1'b0);
    i_host.clear_flag();
    cycles(2);
    chk_bit(flag, 1'b0);
    chk_bit(irq_n, 1'b1);
    i_host.write_trim(4'hb);
    for (int i = 0; i < 5; i++) begin
      wait_change();
      chk_code(code, walk[i]);
      if (i > 0) begin
        chk_bit(n >= STEP_CYC, 1'b1);
      end
      if (i < 4) begin
        chk_bit(flag, 1'b0);
        chk_bit(stepping, 1'b1);
      end
    end
    wait_flag();
    i_host.clear_flag();
    for (int c = 5; c < 16; c++) begin
      if (c < 9 || c > 12) begin
        i_host.write_trim(c[3:0]);
      end
    end
    cycles(8);
    chk_code(tgt, 4'hb);
    chk_bit(stepping, 1'b0);
    i_host.sync_to(4'hc);
    i_host.write_trim(4'h0);
    cycles(4);
    chk_code(tgt, 4'hc);
    i_host.set_modes(1'b1, 1'b1, 1'b0);
    cycles(3);
    chk_bit(spread, 1'b0);
    i_host.set_modes(1'b1, 1'b0, 1'b0);
    i_host.write_trim(4'h0);
    cycles(3);
    chk_bit(spread, 1'b1);
    chk_code(tgt, 4'hc);
    i_host.set_modes(1'b0, 1'b0, 1'b1);
    wait_flag();
    chk_code(code, 4'hc);
    cycles(3);
    chk_bit(irq_n, 1'b1);
    i_host.set_modes(1'b0, 1'b0, 1'b0);
    cycles(3);
    chk_bit(irq_n, 1'b0);
    i_host.clear_flag();
    i_host.write_trim(4'h2);
    wait_change();
    chk_code(code, 4'h0);
    i_host.set_modes(1'b1, 1'b0, 1'b0);
    cycles(400);
    chk_code(code, 4'h0);
    chk_bit(flag, 1'b0);
    chk_bit(stepping, 1'b1);
    i_host.set_modes(1'b0, 1'b0, 1'b0);
    wait_flag();
    chk_code(code, 4'h2);
    n = 0;
    bad = 0;
    @(posedge osc);
    #1;
    p = sw_clk;
    hist = {1'b0, phase[1]};
    for (int k = 0; k < 32; k++) begin
      @(posedge osc);
      #1;
      n += int'(sw_clk && !p);
      p = sw_clk;
      if (k >= 1 && sw_clk !== hist[1]) bad++;
      if (phase[2] !== !sw_clk) bad++;
      hist = {hist[0], phase[1]};
    end
    chk_bit(n == 4, 1'b1);
    chk_bit(bad == 0, 1'b1);
    wrap_up();
  end
endmodule
`default_nettype wire
